/* File: pkg/ets_cfg.svh */
// offsets, field positions and counts of the event sample block
`ifndef ETS_CFG_SVH
`define ETS_CFG_SVH
`define ETS_OFF_S5_NS      12'h584
`define ETS_OFF_S5_SEC     12'h588
`define ETS_OFF_S5_PHASE   12'h58C
`define ETS_OFF_S6_NS      12'h590
`define ETS_OFF_S6_SEC     12'h594
`define ETS_OFF_S6_PHASE   12'h598
`define ETS_OFF_UNIT_INDEX 12'h5F0
`define ETS_UNIT_BIT       8
`define ETS_EDGE_BIT       30
`define ETS_NS_MSB         29
`define ETS_PHASE_MSB      2
`define ETS_SLOT_NS        8
`define ETS_PERIOD_NS      40
`define ETS_SLOTS          (`ETS_PERIOD_NS / `ETS_SLOT_NS)
`define ETS_PH_SLOT0       3'h0
`define ETS_PH_SLOT1       3'h1
`define ETS_PH_SLOT2       3'h2
`define ETS_PH_SLOT3       3'h3
`define ETS_PH_SLOT4       3'h4
`define ETS_RESET_WORD     32'h00000000
`endif

/* File: pkg/ets_pkg.sv */
// types of the event sample block
package ets_pkg;
   typedef struct packed {
      logic        edge_dir;
      logic [29:0] nanos;
      logic [31:0] secs;
      logic [2:0]  slot_phase;
   } ets_sample_type;

   typedef struct packed {
      logic        valid;
      logic        unit;
      logic [1:0]  which;
      logic        edge_dir;
      logic [29:0] nanos;
      logic [31:0] secs;
      logic [2:0]  slot;
   } ets_capture_type;

   typedef struct packed {
      ets_sample_type [1:0][1:0] sample;
      logic                      unit_sel;
      logic [31:0]               prdata;
      logic                      pslverr;
   } ets_state_type;
endpackage : ets_pkg

/* File: design/ets_samples.sv */
// register store for the fifth and sixth event timestamp samples
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "ets_cfg.svh"
module ets_samples
   import ets_pkg::*;
#(
   parameter int UNITS = 2
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            clk_en,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire ets_capture_type capture,
   output logic                 unit_sel
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ets_state_type state;
   ets_state_type next_state;
   logic          access;
   logic          setup;
   logic [2:0]    phase_code;
   logic [31:0]   read_word;
   logic          read_hit;
   ets_sample_type sel5;
   ets_sample_type sel6;

   assign access   = psel & penable;
   assign setup    = psel & ~penable;
   assign pready   = 1'b1;
   assign prdata   = state.prdata;
   assign pslverr  = state.pslverr;
   assign unit_sel = state.unit_sel;

   // ------------------------------------------------------------
   // slot to phase code
   // ------------------------------------------------------------
   always_comb begin
      case (capture.slot)
         3'h0:    phase_code = `ETS_PH_SLOT0;
         3'h1:    phase_code = `ETS_PH_SLOT1;
         3'h2:    phase_code = `ETS_PH_SLOT2;
         3'h3:    phase_code = `ETS_PH_SLOT3;
         3'h4:    phase_code = `ETS_PH_SLOT4;
         default: phase_code = `ETS_PH_SLOT0;
      endcase
   end

   // ------------------------------------------------------------
   // read decode
   // ------------------------------------------------------------
   always_comb begin
      sel5      = state.sample[state.unit_sel][0];
      sel6      = state.sample[state.unit_sel][1];
      read_word = `ETS_RESET_WORD;
      read_hit  = 1'b1;
      case (paddr)
         `ETS_OFF_S5_NS:      read_word = {1'b0, sel5.edge_dir, sel5.nanos};
         `ETS_OFF_S5_SEC:     read_word = sel5.secs;
         `ETS_OFF_S5_PHASE:   read_word = {29'h0, sel5.slot_phase};
         `ETS_OFF_S6_NS:      read_word = {1'b0, sel6.edge_dir, sel6.nanos};
         `ETS_OFF_S6_SEC:     read_word = sel6.secs;
         `ETS_OFF_S6_PHASE:   read_word = {29'h0, sel6.slot_phase};
         `ETS_OFF_UNIT_INDEX: read_word = {23'h0, state.unit_sel, 8'h00};
         default:             read_hit  = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      // answer loaded in setup so it stands through the access phase
      if (setup) begin
         next_state.prdata  = pwrite ? `ETS_RESET_WORD : read_word;
         next_state.pslverr = ~read_hit
            | (pwrite & (paddr != `ETS_OFF_UNIT_INDEX));
      end
      if (access && pwrite && paddr == `ETS_OFF_UNIT_INDEX) begin
         next_state.unit_sel = pwdata[`ETS_UNIT_BIT];
      end
      if (capture.valid && capture.which < 2'd2) begin
         // whole sample written in one cycle
         next_state.sample[capture.unit][capture.which[0]] = '{
            edge_dir:   capture.edge_dir,
            nanos:      capture.nanos,
            secs:       capture.secs,
            slot_phase: phase_code};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // unit index pointer
   chk_unit_select: assert property (clk_en && access && pwrite
      && paddr == `ETS_OFF_UNIT_INDEX |=> unit_sel == $past(pwdata[8]))
      else $error("unit index not taken from bit 8");
   chk_unit_hold: assert property (!(clk_en && access && pwrite
      && paddr == `ETS_OFF_UNIT_INDEX) |=> $stable(unit_sel))
      else $error("unit index changed without a write");
   chk_index_read: assert property ($past(clk_en && setup) && access && !pwrite
      && paddr == `ETS_OFF_UNIT_INDEX |-> prdata == {23'h0, $past(unit_sel), 8'h00})
      else $error("unit index read wrong");

   // read words, valid in the access phase
   chk_edge_reserved: assert property ($past(clk_en && setup) && access && !pwrite
      && (paddr == `ETS_OFF_S5_NS || paddr == `ETS_OFF_S6_NS) |-> !prdata[31])
      else $error("reserved bit 31 set");
   chk_phase_legal: assert property ($past(clk_en && setup) && access && !pwrite
      && (paddr == `ETS_OFF_S5_PHASE || paddr == `ETS_OFF_S6_PHASE)
      |-> prdata[31:3] == 29'h0 && prdata[2:0] <= 3'h4)
      else $error("phase word out of range");
   chk_ns5_read: assert property ($past(clk_en && setup) && access && !pwrite
      && paddr == `ETS_OFF_S5_NS |-> prdata[29:0] == $past(sel5.nanos)
      && prdata[30] == $past(sel5.edge_dir))
      else $error("fifth nanoseconds read wrong");
   chk_sec5_read: assert property ($past(clk_en && setup) && access && !pwrite
      && paddr == `ETS_OFF_S5_SEC |-> prdata == $past(sel5.secs))
      else $error("fifth seconds read wrong");
   chk_phase5_read: assert property ($past(clk_en && setup) && access && !pwrite
      && paddr == `ETS_OFF_S5_PHASE |-> prdata[2:0] == $past(sel5.slot_phase))
      else $error("fifth phase read wrong");
   chk_ns6_read: assert property ($past(clk_en && setup) && access && !pwrite
      && paddr == `ETS_OFF_S6_NS |-> prdata[29:0] == $past(sel6.nanos)
      && prdata[30] == $past(sel6.edge_dir))
      else $error("sixth nanoseconds read wrong");
   chk_sec6_read: assert property ($past(clk_en && setup) && access && !pwrite
      && paddr == `ETS_OFF_S6_SEC |-> prdata == $past(sel6.secs))
      else $error("sixth seconds read wrong");
   chk_phase6_read: assert property ($past(clk_en && setup) && access && !pwrite
      && paddr == `ETS_OFF_S6_PHASE |-> prdata[2:0] == $past(sel6.slot_phase))
      else $error("sixth phase read wrong");

   // error responses
   chk_ro_write: assert property ($past(clk_en && setup) && access && pwrite
      && paddr inside {`ETS_OFF_S5_NS, `ETS_OFF_S5_SEC, `ETS_OFF_S5_PHASE, `ETS_OFF_S6_NS,
      `ETS_OFF_S6_SEC, `ETS_OFF_S6_PHASE} |-> pslverr)
      else $error("write to read-only not flagged");
   chk_read_ok: assert property ($past(clk_en && setup) && access && !pwrite && read_hit
      |-> !pslverr)
      else $error("mapped read flagged as error");
   chk_unmapped: assert property ($past(clk_en && setup) && access && !read_hit
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not flagged");

   // phase encoding of captured samples
   chk_phase_slot0: assert property (clk_en && capture.valid && capture.which == 2'd0
      && capture.slot == 3'h0 |=> state.sample[$past(capture.unit)][0].slot_phase == 3'h0)
      else $error("0 ns slot misencoded");
   chk_phase_slot1: assert property (clk_en && capture.valid && capture.which == 2'd0
      && capture.slot == 3'h1 |=> state.sample[$past(capture.unit)][0].slot_phase == 3'h1)
      else $error("8 ns slot misencoded");
   chk_phase_slot2: assert property (clk_en && capture.valid && capture.which == 2'd0
      && capture.slot == 3'h2 |=> state.sample[$past(capture.unit)][0].slot_phase == 3'h2)
      else $error("16 ns slot misencoded");
   chk_phase_slot3: assert property (clk_en && capture.valid && capture.which == 2'd0
      && capture.slot == 3'h3 |=> state.sample[$past(capture.unit)][0].slot_phase == 3'h3)
      else $error("24 ns slot misencoded");
   chk_phase_slot4: assert property (clk_en && capture.valid && capture.which == 2'd0
      && capture.slot == 3'h4 |=> state.sample[$past(capture.unit)][0].slot_phase == 3'h4)
      else $error("32 ns slot misencoded");
   chk_phase6_code: assert property (clk_en && capture.valid && capture.which == 2'd1
      && capture.slot <= 3'h4
      |=> state.sample[$past(capture.unit)][1].slot_phase == $past(capture.slot))
      else $error("sixth phase code wrong");
   chk_phase_no_reserved: assert property (clk_en && capture.valid
      && capture.which < 2'd2
      |=> state.sample[$past(capture.unit)][$past(capture.which[0])].slot_phase <= 3'h4)
      else $error("reserved phase code stored");

   // whole-sample update and freeze
   chk_sample5_whole: assert property (clk_en && capture.valid && capture.which == 2'd0
      |=> state.sample[$past(capture.unit)][0].secs == $past(capture.secs)
      && state.sample[$past(capture.unit)][0].nanos == $past(capture.nanos)
      && state.sample[$past(capture.unit)][0].edge_dir == $past(capture.edge_dir))
      else $error("fifth sample not updated whole");
   chk_sample_whole: assert property (clk_en && capture.valid && capture.which == 2'd1
      |=> state.sample[$past(capture.unit)][1].secs == $past(capture.secs)
      && state.sample[$past(capture.unit)][1].nanos == $past(capture.nanos)
      && state.sample[$past(capture.unit)][1].edge_dir == $past(capture.edge_dir))
      else $error("sixth sample not updated whole");
   chk_enable_freeze: assert property (!clk_en |=> $stable(state))
      else $error("state moved while clock enable low");

   cov_capture5: cover property (capture.valid && capture.which == 2'd0);
   cov_capture6: cover property (capture.valid && capture.which == 2'd1);
   cov_unit_one: cover property (unit_sel && access && paddr == `ETS_OFF_S6_SEC);
   cov_unmapped: cover property (setup && !read_hit ##1 access && pslverr);

endmodule : ets_samples

/* File: bench/ets_event_src.sv */
// event source model feeding captured samples into the block
`timescale 1ns/10ps
module ets_event_src
   import ets_pkg::*;
(
   input  wire logic       pclk,
   output ets_capture_type capture
);
   initial capture = '0;
   // one-cycle pulse carrying every field of one sample
   task automatic send(input logic u, input logic [1:0] w, input logic e,
                       input logic [29:0] ns, input logic [31:0] s, input logic [2:0] sl);
      capture <= '{1'b1, u, w, e, ns, s, sl};
      @(posedge pclk);
      // released fields show the inverse of the last value
      capture <= '{1'b0, ~u, ~w, ~e, ~ns, ~s, ~sl};
   endtask : send
endmodule : ets_event_src

/* File: bench/event_timestamp_samples_five_six_tb.sv */
// self-checking bench of the fifth and sixth event sample registers
`timescale 1ns/10ps
`include "ets_cfg.svh"
module event_timestamp_samples_five_six_tb
   import ets_pkg::*;
();
   logic            pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
   logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]     paddr = 12'h000;
   logic [31:0]     pwdata = 32'h0, prdata, rd, mdl [0:1][0:5];
   logic            pready, pslverr, unit_sel, u, err;
   logic [1:0]      w;
   ets_capture_type capture;
   integer          seed = 32'h484A, num_errors = 0, checked = 0;
   always #20 pclk = ~pclk;
   ets_event_src u_ets_event_src (.pclk(pclk), .capture(capture));
   ets_samples #(.UNITS(2)) u_ets_samples (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture(capture),
      .unit_sel(unit_sel));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic read_all(input logic un);
      for (int k = 0; k < 6; k++) begin
         apb(1'b0, `ETS_OFF_S5_NS + 12'(4 * k), 32'h0);
         check("sample word", mdl[un][k], rd);
         check("sample pslverr", 32'h0, {31'h0, err});
      end
   endtask : read_all
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      foreach (mdl[i, k]) mdl[i][k] = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      read_all(1'b0);
      for (int i = 0; i < 20; i++) begin
         u = i[0];
         w = {1'b0, i[1]};
         apb(1'b1, `ETS_OFF_UNIT_INDEX, {23'h0, u, 8'h0});
         check("unit_sel", {31'h0, u}, {31'h0, unit_sel});
         apb(1'b0, `ETS_OFF_UNIT_INDEX, 32'h0);
         check("unit index", {23'h0, u, 8'h0}, rd);
         mdl[u][3 * w] = $random(seed) & 32'h7FFFFFFF;
         mdl[u][3 * w + 1] = $random(seed);
         // slot 16 ns taken as 010
         mdl[u][3 * w + 2] = {29'h0, 3'(i % 5)};
         u_ets_event_src.send(u, w, mdl[u][3 * w][30], mdl[u][3 * w][29:0],
                              mdl[u][3 * w + 1], 3'(i % 5));
         read_all(u);
      end
      clk_en <= 1'b0;
      u_ets_event_src.send(u, 2'd1, 1'b1, 30'h3, 32'h5, 3'h2);
      clk_en <= 1'b1;
      read_all(u);
      apb(1'b1, `ETS_OFF_S6_SEC, 32'hFFFFFFFF);
      check("ro write pslverr", 32'h1, {31'h0, err});
      apb(1'b0, `ETS_OFF_S6_SEC, 32'h0);
      check("ro word kept", mdl[u][4], rd);
      apb(1'b0, 12'h5FC, 32'h0);
      check("unmapped read", 32'h0, rd);
      check("unmapped pslverr", 32'h1, {31'h0, err});
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      foreach (mdl[i, k]) mdl[i][k] = 32'h0;
      read_all(1'b0);
      check("unit_sel reset", 32'h0, {31'h0, unit_sel});
      tally_and_finish();
   end
endmodule : event_timestamp_samples_five_six_tb
